// File: src/pbm_regs.sv
// Basic management registers (control, status, identifier high)
// behind a clause 22 serial management port.
// Assumes management clock and data and the straps are asynchronous
// pins; link status inputs come from logic on the device clock.
`timescale 1ns/1ps
`default_nettype none
module pbm_regs
  import pbm_pkg::*;
#(
  // Arbitrary value, not a real maker's code
  parameter logic [15:0] ID_HI_RESET = 16'h5A5A,
  parameter int SRST_CYC = SOFT_RST_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Management port pins
  input wire logic mdc,
  input wire logic mdio_i,
  output var logic mdio_o,
  output var logic mdio_oe,
  // Mode straps
  input wire pbm_strap_t strap_i,
  // Core status and negotiated result
  input wire pbm_stat_t stat_i,
  input wire logic [1:0] an_speed,
  input wire logic an_duplex,
  // Control toward the core
  output var pbm_ctrl_t ctrl_o,
  output var logic [1:0] line_speed_o,
  output var logic line_fdx_o,
  output var logic soft_rst_o,
  output var logic an_restart_o
);

  logic [1:0] rs_q;
  logic rst_n;
  logic mdc_s;
  logic mdio_s;
  logic mdc_q;
  logic rise;
  pbm_strap_t strap_s;
  pbm_strap_t strap_q;
  logic [1:0] strap_cnt_q;
  logic strap_ld;
  pbm_state_t st_q;
  logic [5:0] cnt_q;
  logic [12:0] hdr_q;
  logic [12:0] hdr_d;
  logic hdr_end;
  logic frame_ok;
  logic rd_q;
  logic [4:0] reg_q;
  logic [15:0] sh_q;
  logic ta_rd;
  logic wr_done;
  logic [15:0] wdata;
  logic wr_ctrl;
  logic wr_id;
  logic rd_stat;
  logic [15:0] rdata;
  logic [15:0] ctrl_rd;
  logic [15:0] stat_rd;
  logic [15:0] id_q;
  logic busy_q;
  logic [15:0] srst_cnt_q;
  logic rf_q;
  logic jab_q;
  logic link_q;
  logic rf_rd_q;
  logic jab_rd_q;
  logic link_rd_q;

  // Reset release through two flops
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rs_q <= 2'h0;
    else
      rs_q <= {rs_q[0], 1'b1};
  end
  assign rst_n = rs_q[1];

  pbm_sync #(
    .W(STRAP_W + 2)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({strap_i, mdc, mdio_i}),
    .q({strap_s, mdc_s, mdio_s})
  );

  // Edge finder on the synchronised management clock
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mdc_q <= 1'b0;
    else
      mdc_q <= mdc_s;
  end
  assign rise = mdc_s & ~mdc_q;

  // Straps settle through the synchroniser before capture
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_cnt_q <= 2'h0;
      strap_q <= '0;
    end
    else if (strap_cnt_q != STRAP_WAIT)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      strap_q <= strap_s;
    end
  end
  assign strap_ld = (strap_cnt_q == STRAP_WAIT - 2'h1);

  // Frame decode
  assign hdr_d = {hdr_q[11:0], mdio_s};
  assign hdr_end = rise && (st_q == ST_HDR) && (cnt_q == HDR_BITS - 6'h1);
  assign frame_ok = hdr_d[12]
    && (hdr_d[11:10] == OP_READ || hdr_d[11:10] == OP_WRITE)
    && (hdr_d[9:5] == strap_q.phy_addr);
  assign ta_rd = rise && (st_q == ST_TA) && rd_q;
  assign wr_done = rise && (st_q == ST_WR)
    && (cnt_q == DATA_BITS - 6'h1);
  assign wdata = {sh_q[14:0], mdio_s};
  assign wr_ctrl = wr_done && (reg_q == REG_CTRL) && !busy_q;
  assign wr_id = wr_done && (reg_q == REG_ID_HI);
  assign rd_stat = ta_rd && (reg_q == REG_STAT);

  // Frame sequencer, one step per management clock rise
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_PRE;
      cnt_q <= 6'h0;
    end
    else if (rise)
    begin
      unique case (st_q)
        ST_PRE:
        begin
          if (mdio_s)
            cnt_q <= (cnt_q == PRE_BITS) ? cnt_q : cnt_q + 6'h1;
          else if (cnt_q == PRE_BITS)
          begin
            st_q <= ST_HDR;
            cnt_q <= 6'h0;
          end
          else
            cnt_q <= 6'h0;
        end
        ST_HDR:
        begin
          cnt_q <= cnt_q + 6'h1;
          if (hdr_end)
          begin
            cnt_q <= 6'h0;
            st_q <= frame_ok ? ST_TA : ST_PRE;
          end
        end
        ST_TA:
        begin
          cnt_q <= cnt_q + 6'h1;
          if (rd_q || cnt_q == 6'h1)
          begin
            cnt_q <= 6'h0;
            st_q <= rd_q ? ST_RD : ST_WR;
          end
        end
        ST_WR:
        begin
          cnt_q <= cnt_q + 6'h1;
          if (wr_done)
          begin
            cnt_q <= 6'h0;
            st_q <= ST_PRE;
          end
        end
        ST_RD:
        begin
          cnt_q <= cnt_q + 6'h1;
          if (cnt_q == DATA_BITS)
          begin
            cnt_q <= 6'h0;
            st_q <= ST_PRE;
          end
        end
      endcase
    end
  end

  // Header capture
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hdr_q <= 13'h0000;
      rd_q <= 1'b0;
      reg_q <= 5'h00;
    end
    else if (rise && st_q == ST_HDR)
    begin
      hdr_q <= hdr_d;
      if (hdr_end)
      begin
        rd_q <= (hdr_d[11:10] == OP_READ);
        reg_q <= hdr_d[4:0];
      end
    end
  end

  // Read data, snapshot taken at the first turnaround bit
  assign ctrl_rd = {busy_q, ctrl_o.loopback, ctrl_o.speed[0],
    ctrl_o.an_enable, ctrl_o.power_down, ctrl_o.isolate,
    an_restart_o, ctrl_o.full_duplex, ctrl_o.col_test,
    ctrl_o.speed[1], 6'h00};

  always_comb
  begin
    stat_rd = STAT_CONST;
    stat_rd[SB_AN_DONE] = stat_i.an_done;
    stat_rd[SB_RFAULT] = rf_q;
    stat_rd[SB_LINK] = link_q;
    stat_rd[SB_JABBER] = jab_q;
  end

  always_comb
  begin
    unique case (reg_q)
      REG_CTRL: rdata = ctrl_rd;
      REG_STAT: rdata = stat_rd;
      REG_ID_HI: rdata = id_q;
      default: rdata = 16'h0000;
    endcase
  end

  // Shift register and data pin drive
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_q <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end
    else if (ta_rd)
    begin
      // Turnaround second bit is driven low
      sh_q <= rdata;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b1;
    end
    else if (rise && st_q == ST_RD)
    begin
      if (cnt_q == DATA_BITS)
      begin
        mdio_o <= 1'b0;
        mdio_oe <= 1'b0;
      end
      else
      begin
        mdio_o <= sh_q[15];
        sh_q <= {sh_q[14:0], 1'b0};
      end
    end
    else if (rise && st_q == ST_WR)
      sh_q <= wdata;
  end

  // Control register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_o <= '0;
    else if (strap_ld || (wr_ctrl && wdata[CB_RESET]))
    begin
      // Other written bits ignored; soft reset reloads defaults
      ctrl_o <= '0;
      ctrl_o.speed <= strap_ld ? strap_s.speed : strap_q.speed;
      ctrl_o.an_enable <= strap_ld ? strap_s.an_enable
        : strap_q.an_enable;
      ctrl_o.full_duplex <= strap_ld ? strap_s.full_duplex
        : strap_q.full_duplex;
    end
    else if (wr_ctrl)
    begin
      ctrl_o.loopback <= wdata[CB_LOOP];
      ctrl_o.speed[0] <= wdata[CB_SPD0];
      ctrl_o.an_enable <= wdata[CB_ANEN];
      ctrl_o.power_down <= wdata[CB_PDOWN];
      ctrl_o.isolate <= wdata[CB_ISO];
      ctrl_o.full_duplex <= wdata[CB_DUPLEX];
      ctrl_o.col_test <= wdata[CB_COLTST];
    end
  end

  // Soft reset timer; the bit reads one until it runs out
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      srst_cnt_q <= 16'h0000;
      soft_rst_o <= 1'b0;
    end
    else if (wr_ctrl && wdata[CB_RESET])
    begin
      busy_q <= 1'b1;
      soft_rst_o <= 1'b1;
      srst_cnt_q <= 16'h0000;
    end
    else if (busy_q)
    begin
      srst_cnt_q <= srst_cnt_q + 16'h0001;
      if (srst_cnt_q == 16'(SRST_CYC - 1))
      begin
        busy_q <= 1'b0;
        soft_rst_o <= 1'b0;
      end
    end
  end

  // Restart is a one-cycle pulse; writing zero does nothing
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      an_restart_o <= 1'b0;
    else
      an_restart_o <= wr_ctrl && !wdata[CB_RESET]
        && wdata[CB_ANRST];
  end

  // Effective line settings toward the core
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_speed_o <= 2'h0;
      line_fdx_o <= 1'b0;
    end
    else if (ctrl_o.an_enable)
    begin
      line_speed_o <= an_speed;
      line_fdx_o <= an_duplex;
    end
    else
    begin
      line_speed_o <= ctrl_o.speed;
      line_fdx_o <= ctrl_o.full_duplex;
    end
  end

  // Latched status; a new event wins over the read clear.
  // A read seen while latched lets the bit follow its cause afterwards.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_q <= 1'b0;
      jab_q <= 1'b0;
      link_q <= 1'b0;
      rf_rd_q <= 1'b0;
      jab_rd_q <= 1'b0;
      link_rd_q <= 1'b0;
    end
    else
    begin
      rf_q <= stat_i.remote_fault
        | (rf_q & ~rd_stat & ~rf_rd_q);
      jab_q <= stat_i.jabber
        | (jab_q & ~rd_stat & ~jab_rd_q);
      link_q <= stat_i.link_up
        & (link_q | rd_stat | link_rd_q);
      rf_rd_q <= (rf_rd_q | (rd_stat & rf_q))
        & stat_i.remote_fault;
      jab_rd_q <= (jab_rd_q | (rd_stat & jab_q))
        & stat_i.jabber;
      link_rd_q <= (link_rd_q | (rd_stat & ~link_q))
        & ~stat_i.link_up;
    end
  end

  // Identifier high, kept through soft reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      id_q <= ID_HI_RESET;
    else if (wr_id)
      id_q <= wdata;
  end

endmodule : pbm_regs
`default_nettype wire

// File: src/pbm_pkg.sv
// Package for the basic management register set: register indices,
// field positions, constant values, frame timing and carrier types.
// Assumes a 200 MHz device clock and a clause 22 management frame.
package pbm_pkg;

  // Device clock and soft reset length
  localparam int CLK_PERIOD_NS = 5;
  localparam int SOFT_RST_NS = 80;
  localparam int SOFT_RST_CYC = (SOFT_RST_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;

  // Register indices
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ID_HI = 5'h02;

  // Control register bit positions
  localparam int CB_RESET = 15;
  localparam int CB_LOOP = 14;
  localparam int CB_SPD0 = 13;
  localparam int CB_ANEN = 12;
  localparam int CB_PDOWN = 11;
  localparam int CB_ISO = 10;
  localparam int CB_ANRST = 9;
  localparam int CB_DUPLEX = 8;
  localparam int CB_COLTST = 7;
  localparam int CB_SPD1 = 6;

  // Status register bit positions and constant ability bits
  localparam int SB_AN_DONE = 5;
  localparam int SB_RFAULT = 4;
  localparam int SB_LINK = 2;
  localparam int SB_JABBER = 1;
  localparam logic [15:0] STAT_CONST = 16'h7909;

  // Management frame layout
  localparam logic [5:0] PRE_BITS = 6'h20;
  localparam logic [5:0] HDR_BITS = 6'h0D;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // Strap sampling delay after reset release
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [2:0] {
    ST_PRE = 3'b000,
    ST_HDR = 3'b001,
    ST_TA = 3'b011,
    ST_WR = 3'b010,
    ST_RD = 3'b110
  } pbm_state_t;

  typedef struct packed {
    logic loopback;
    logic [1:0] speed;
    logic an_enable;
    logic power_down;
    logic isolate;
    logic full_duplex;
    logic col_test;
  } pbm_ctrl_t;

  typedef struct packed {
    logic link_up;
    logic jabber;
    logic remote_fault;
    logic an_done;
  } pbm_stat_t;

  typedef struct packed {
    logic [1:0] speed;
    logic an_enable;
    logic full_duplex;
    logic [4:0] phy_addr;
  } pbm_strap_t;

  localparam int STRAP_W = $bits(pbm_strap_t);

endpackage : pbm_pkg

// File: src/pbm_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is a slow level; multi-bit words are not coherent.
`timescale 1ns/1ps
`default_nettype none
module pbm_sync
  import pbm_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : pbm_sync
`default_nettype wire

// File: dv/pbm_sva.sv
// Checker for the management register block's top ports.
// Assumes a bind to every pbm_regs instance.
`timescale 1ns/1ps
`default_nettype none
module pbm_sva
  import pbm_pkg::*;
#(
  parameter int SRST_CYC = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Watched ports
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire pbm_strap_t strap_i,
  input wire logic [1:0] an_speed,
  input wire logic an_duplex,
  input wire pbm_ctrl_t ctrl_o,
  input wire logic [1:0] line_speed_o,
  input wire logic line_fdx_o,
  input wire logic soft_rst_o,
  input wire logic an_restart_o
);
  logic [1:0] sel_spd;
  logic sel_fdx;
  logic [9:0] oe_cnt_q;
  logic [5:0] sr_cnt_q;
  logic [2:0] up_cnt_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  assign sel_spd = ctrl_o.an_enable ? an_speed : ctrl_o.speed;
  assign sel_fdx = ctrl_o.an_enable ? an_duplex : ctrl_o.full_duplex;
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) oe_cnt_q <= '0;
    else oe_cnt_q <= mdio_oe ? oe_cnt_q + 10'h001 : '0;
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) sr_cnt_q <= '0;
    else sr_cnt_q <= soft_rst_o ? sr_cnt_q + 6'h01 : '0;
  // Settling time after release, saturates
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n) up_cnt_q <= '0;
    else if (up_cnt_q != 3'h7) up_cnt_q <= up_cnt_q + 3'h1;
  sequence s_sr_done;
    $fell(soft_rst_o);
  endsequence
  sequence s_drive_end;
    $fell(mdio_oe);
  endsequence
  a_restart_pulse: assert property (an_restart_o |=> !an_restart_o)
    else $error("restart pulse too long");
  a_restart_busy: assert property (soft_rst_o |-> !an_restart_o)
    else $error("restart during soft reset");
  a_line_select: assert property (up_cnt_q == 3'h7 |->
    line_speed_o == $past(sel_spd) && line_fdx_o == $past(sel_fdx))
    else $error("line mode wrong");
  a_sr_length: assert property (s_sr_done |-> sr_cnt_q == SRST_CYC)
    else $error("soft reset length wrong");
  a_sr_clean: assert property (s_sr_done |-> !(ctrl_o.loopback ||
    ctrl_o.power_down || ctrl_o.isolate || ctrl_o.col_test))
    else $error("mode left after soft reset");
  a_strap_load: assert property (up_cnt_q == 3'h6 |=>
    ctrl_o.speed == strap_i.speed && ctrl_o.an_enable ==
    strap_i.an_enable && ctrl_o.full_duplex == strap_i.full_duplex)
    else $error("strap values not loaded");
  a_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_o)
    else $error("turnaround not zero");
  a_drive_span: assert property (s_drive_end |->
    oe_cnt_q inside {[540:548]})
    else $error("read drive span wrong");
  a_ctrl_quiet: assert property ($changed(ctrl_o) |-> !mdio_oe)
    else $error("control changed during read");
endmodule : pbm_sva
bind pbm_regs pbm_sva #(.SRST_CYC(SRST_CYC)) pbm_sva_i (
  .clock(clock), .arst_n(arst_n), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
  .strap_i(strap_i), .an_speed(an_speed), .an_duplex(an_duplex),
  .ctrl_o(ctrl_o), .line_speed_o(line_speed_o), .line_fdx_o(line_fdx_o),
  .soft_rst_o(soft_rst_o), .an_restart_o(an_restart_o));
`default_nettype wire

// File: dv/pbm_mgr.sv
// Station manager model issuing clause 22 frames.
// Assumes mdio_w is the resolved, pulled-up wire level.
`timescale 1ns/1ps
`default_nettype none
module pbm_mgr
  import pbm_pkg::*;
(
  // Management pins
  output var logic mdc,
  output var logic m_o,
  output var logic m_oe,
  input wire logic mdio_w
);
  // Clock stands low between frames
  initial
  begin
    mdc = 1'b0;
    m_o = 1'b1;
    m_oe = 1'b0;
  end
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = '0;
    #2.3;
    for (int i = 63; i >= 0; i--)
    begin
      m_o = f[i];
      // Read frames release the wire from turnaround on
      m_oe = (op == OP_WRITE) || (i > 17);
      #80 mdc = 1'b1;
      if (i < 16) rd[i] = mdio_w;
      #80 mdc = 1'b0;
    end
    m_oe = 1'b0;
    #200;
  endtask : xfer
endmodule : pbm_mgr
`default_nettype wire

// File: dv/test_phy_basic_mgmt_registers.sv
// Bench for the basic management registers.
// Assumes the pbm_mgr model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_phy_basic_mgmt_registers
  import pbm_pkg::*;
;
  typedef struct packed {
    logic [15:0] wd;
    logic [15:0] rd;
    logic [1:0] ls;
    logic lf;
  } pbm_row_t;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  pbm_strap_t strap = {2'h2, 1'b0, 1'b1, 5'h05};
  pbm_stat_t stat = '0;
  logic [1:0] an_speed = 2'h1;
  logic an_duplex = 1'b0;
  logic mdc, m_o, m_oe, mdio_o, mdio_oe;
  pbm_ctrl_t ctrl;
  logic [1:0] line_speed;
  logic line_fdx, soft_rst, an_restart;
  wire logic mdio_w = mdio_oe ? mdio_o : (m_oe ? m_o : 1'b1);
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_pulse = 0;
  int n_srst = 0;
  logic [15:0] junk;
  pbm_row_t rows [7] = '{{16'h4000, 16'h4040, 2'h2, 1'b0},
    {16'h2000, 16'h2040, 2'h3, 1'b0}, {16'h0800, 16'h0840, 2'h2, 1'b0},
    {16'h0400, 16'h0440, 2'h2, 1'b0}, {16'h0080, 16'h00C0, 2'h2, 1'b0},
    {16'h013F, 16'h0140, 2'h2, 1'b1}, {16'h1100, 16'h1140, 2'h1, 1'b0}};
  always #2.5 clock = ~clock;
  pbm_regs #(.SRST_CYC(4)) pbm_regs_i (.clock(clock), .arst_n(arst_n),
    .mdc(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .strap_i(strap), .stat_i(stat), .an_speed(an_speed),
    .an_duplex(an_duplex), .ctrl_o(ctrl), .line_speed_o(line_speed),
    .line_fdx_o(line_fdx), .soft_rst_o(soft_rst),
    .an_restart_o(an_restart));
  pbm_mgr pbm_mgr_i (.mdc(mdc), .m_o(m_o), .m_oe(m_oe), .mdio_w(mdio_w));
  task automatic complete_run();
    $display("mismatches %0d, tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  always @(posedge clock)
  begin
    cyc++;
    n_pulse += (an_restart === 1'b1);
    n_srst += (soft_rst === 1'b1);
    if (cyc == 90000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    pbm_mgr_i.xfer(OP_WRITE, strap.phy_addr, ra, wd, d);
  endtask : wr
  task automatic rdc(input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] exp);
    logic [15:0] d;
    pbm_mgr_i.xfer(OP_READ, pa, ra, 16'h0000, d);
    chk(d, exp);
  endtask : rdc
  initial
  begin
    repeat (8) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (12) @(posedge clock);
    chk({8'h00, ctrl}, 16'h0042);
    rdc(strap.phy_addr, REG_CTRL, 16'h0140);
    foreach (rows[i])
    begin
      wr(REG_CTRL, rows[i].wd);
      rdc(strap.phy_addr, REG_CTRL, rows[i].rd);
      chk({14'h0, line_speed}, {14'h0, rows[i].ls});
      chk({15'h0, line_fdx}, {15'h0, rows[i].lf});
    end
    // Awkward cases: restart, identifier, refusals, soft reset
    wr(REG_CTRL, 16'h1200);
    chk(16'(n_pulse), 16'h0001);
    rdc(strap.phy_addr, REG_CTRL, 16'h1040);
    wr(REG_CTRL, 16'h1000);
    chk(16'(n_pulse), 16'h0001);
    rdc(strap.phy_addr, REG_ID_HI, 16'h5A5A);
    wr(REG_ID_HI, 16'h1234);
    rdc(strap.phy_addr, REG_ID_HI, 16'h1234);
    rdc(strap.phy_addr, 5'h07, 16'h0000);
    rdc(5'h06, REG_CTRL, 16'hFFFF);
    // Bad opcode: frame ignored, wire stays high; foreign address write: frame ignored
    pbm_mgr_i.xfer(2'h3, strap.phy_addr, REG_CTRL, 16'h0000, junk);
    chk(junk, 16'hFFFF);
    pbm_mgr_i.xfer(OP_WRITE, 5'h06, REG_CTRL, 16'h4000, junk);
    rdc(strap.phy_addr, REG_CTRL, 16'h1040);
    wr(REG_STAT, 16'h0000);
    wr(REG_CTRL, 16'h4480);
    wr(REG_CTRL, 16'h8000);
    chk(16'(n_srst), 16'h0004);
    rdc(strap.phy_addr, REG_CTRL, 16'h0140);
    rdc(strap.phy_addr, REG_ID_HI, 16'h1234);
    @(posedge clock) #1 stat = '1;
    @(posedge clock) #1 stat = 4'h9;
    // Causes gone before the read: latches must still show them
    rdc(strap.phy_addr, REG_STAT, 16'h793B);
    rdc(strap.phy_addr, REG_STAT, 16'h792D);
    @(posedge clock) #1 stat.link_up = 1'b0;
    @(posedge clock) #1 stat.link_up = 1'b1;
    rdc(strap.phy_addr, REG_STAT, 16'h7929);
    rdc(strap.phy_addr, REG_STAT, 16'h792D);
    // Read while causes persist, then causes flip: bits follow them
    @(posedge clock) #1 stat = 4'h5;
    rdc(strap.phy_addr, REG_STAT, 16'h792B);
    @(posedge clock) #1 stat = 4'h9;
    rdc(strap.phy_addr, REG_STAT, 16'h792D);
    complete_run();
  end
endmodule : test_phy_basic_mgmt_registers
`default_nettype wire
